// >>> logic/pt_pkg.sv
// constants and register map of the paired timer
// Notes on behaviour
// RQ1 - one 32-bit timer or two 16-bit timers
// RQ2 - split halves: synchronous timer or counter only
// RQ3 - wide mode also offers synchronous 32-bit counting
// RQ4 - gating, prescaling, run during idle or sleep
// RQ5 - wide mode interrupt on 32-bit period match
// RQ6 - conversion trigger from wide pair or high only
// RQ7 - low half lsw, high half msw of count
// RQ8 - wide mode ignores high timer control entirely
// RQ9 - wide uses low clock/gate, high interrupt flag
// RQ10 - control bit 3 set selects wide mode
// RQ11 - prescale field, clock source, gate accumulate bits
// RQ12 - software maps external clock pin before use
// RQ13 - wide period: high word msw, low lsw
// RQ14 - count words read upper and lower halves
// RQ15 - wide interrupt uses high enable and priority
// RQ16 - control bit 15 set starts the timer
// RQ17 - split halves use own period, enable, priority
// RQ18 - software sets run bit last in setup
// RQ19 - match clears count next edge, sets flag
// RQ20 - low all-ones rollover carries into high half
package pt_pkg;
    localparam logic [11:0] PT_LOW_CTRL_ADDR = 12'h000;
    localparam logic [11:0] PT_HIGH_CTRL_ADDR = 12'h004;
    localparam logic [11:0] PT_LOW_PERIOD_ADDR = 12'h008;
    localparam logic [11:0] PT_HIGH_PERIOD_ADDR = 12'h00C;
    localparam logic [11:0] PT_LOW_COUNT_ADDR = 12'h010;
    localparam logic [11:0] PT_HIGH_COUNT_ADDR = 12'h014;
    localparam logic [11:0] PT_IRQ_CTRL_ADDR = 12'h018;
    localparam logic [11:0] PT_IRQ_FLAG_ADDR = 12'h01C;
    localparam int PT_RUN_BIT = 15;
    localparam int PT_IDLE_STOP_BIT = 13;
    localparam int PT_GATE_BIT = 6;
    localparam int PT_PS_HI = 5;
    localparam int PT_PS_LO = 4;
    localparam int PT_WIDE_BIT = 3;
    localparam int PT_CS_BIT = 1;
    localparam logic [15:0] PT_CTRL_MASK = 16'hA07A;
    localparam logic [15:0] PT_PERIOD_RESET = 16'hFFFF;
    localparam int PT_LOW_IE_BIT = 0;
    localparam int PT_HIGH_IE_BIT = 1;
    localparam int PT_LOW_IP_LO = 4;
    localparam int PT_HIGH_IP_LO = 8;
    localparam int PT_IP_WIDTH = 3;
    localparam logic [1:0] PT_HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] PT_HSIZE_WORD = 3'b010;
endpackage

// >>> logic/pt_prescaler.sv
// prescaler and clock/gate qualifier for one timer half
module pt_prescaler
    import pt_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic [1:0] prescaleSelect,
    input wire logic clockSourceSelect,
    input wire logic gateAccumulateEnable,
    input wire logic running,
    // synchronised pins
    input wire logic extClockSync,
    input wire logic gateSync,
    // count enable out
    output logic tick
);
    logic [7:0] divCount;
    logic [7:0] divTop;
    logic extPrev;
    logic srcEvent;
    logic wrap;
    // ratios 1, 8, 64, 256
    assign divTop = (prescaleSelect == 2'd0) ? 8'h00 : (prescaleSelect == 2'd1) ? 8'h07 :
                    (prescaleSelect == 2'd2) ? 8'h3F : 8'hFF; // RQ11
    // gated mode counts system clock only while gate high; external counts rising pin edges
    assign srcEvent = clockSourceSelect ? (extClockSync && !extPrev) :
                      (!gateAccumulateEnable || gateSync); // RQ4 RQ11
    assign wrap = (divCount == divTop);
    assign tick = running && srcEvent && wrap;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCount <= 8'h00;
            extPrev <= 1'b0;
        end else begin
            extPrev <= extClockSync;
            if (!running) begin
                divCount <= 8'h00;
            end else if (srcEvent) begin
                divCount <= wrap ? 8'h00 : divCount + 8'h01;
            end
        end
    end
endmodule // pt_prescaler

// >>> logic/pt_paired_timer.sv
// paired 16/32-bit timer with AHB-Lite register slave
//
// Local design decisions: the address map and the AHB-Lite register port.
module pt_paired_timer
    import pt_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pins from the pin-select fabric
    input wire logic lowExtClock,
    input wire logic highExtClock,
    input wire logic lowGate,
    input wire logic highGate,
    // power state
    input wire logic cpuIdle,
    // events
    output logic lowIrqFlag,
    output logic highIrqFlag,
    output logic lowIrqReq,
    output logic highIrqReq,
    output logic [2:0] lowIrqPriority,
    output logic [2:0] highIrqPriority,
    output logic adcTrigger
);
    logic [15:0] lowCtrl;
    logic [15:0] highCtrl;
    logic [WIDTH-1:0] lowPeriod;
    logic [WIDTH-1:0] highPeriod;
    logic [WIDTH-1:0] lowCount;
    logic [WIDTH-1:0] highCount;
    logic [15:0] irqCtrl;
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [1:0] gA;
    logic [1:0] gB;
    logic lowTick;
    logic highTick;
    logic phaseWrite;
    logic [11:0] phaseAddr;
    logic wideMode;
    logic lowRun;
    logic highRun;
    logic [2*WIDTH-1:0] wideCount;
    logic [2*WIDTH-1:0] widePeriod;
    logic wideMatch;
    logic lowMatch;
    logic highMatch;
    logic lowCarry;
    logic wideEvent;
    logic lowEvent;
    logic highEvent;
    logic addrValid;
    logic [31:0] next_hrdata;
    logic wrLowCtrl;
    logic wrHighCtrl;
    logic wrLowPer;
    logic wrHighPer;
    logic wrLowCnt;
    logic wrHighCnt;
    logic wrIrq;
    logic wrFlag;

    // two-flop synchronisers: syncA and gA are only read by syncB and gB; [1] is the low pin, [0] the high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncA <= 2'b00;
            syncB <= 2'b00;
            gA <= 2'b00;
            gB <= 2'b00;
        end else begin
            syncA <= {lowExtClock, highExtClock};
            syncB <= syncA;
            gA <= {lowGate, highGate};
            gB <= gA;
        end
    end

    assign wideMode = lowCtrl[PT_WIDE_BIT]; // RQ1 RQ10
    // idle-stop bit halts the half while the core idles; sleep keeps counting
    assign lowRun = lowCtrl[PT_RUN_BIT] && !(cpuIdle && lowCtrl[PT_IDLE_STOP_BIT]); // RQ4 RQ16
    assign highRun = !wideMode && highCtrl[PT_RUN_BIT] && !(cpuIdle && highCtrl[PT_IDLE_STOP_BIT]); // RQ8 RQ16

    // low prescaler clocks both halves in wide mode
    pt_prescaler u_lowPre (
        .sys_clk(sys_clk),
        .rst(rst),
        .prescaleSelect(lowCtrl[PT_PS_HI:PT_PS_LO]),
        .clockSourceSelect(lowCtrl[PT_CS_BIT]),
        .gateAccumulateEnable(lowCtrl[PT_GATE_BIT]),
        .running(lowRun),
        .extClockSync(syncB[1]),
        .gateSync(gB[1]),
        .tick(lowTick)
    ); // RQ9
    pt_prescaler u_highPre (
        .sys_clk(sys_clk),
        .rst(rst),
        .prescaleSelect(highCtrl[PT_PS_HI:PT_PS_LO]),
        .clockSourceSelect(highCtrl[PT_CS_BIT]),
        .gateAccumulateEnable(highCtrl[PT_GATE_BIT]),
        .running(highRun),
        .extClockSync(syncB[0]),
        .gateSync(gB[0]),
        .tick(highTick)
    ); // RQ2

    assign wideCount = {highCount, lowCount}; // RQ7
    assign widePeriod = {highPeriod, lowPeriod}; // RQ13
    assign wideMatch = (wideCount == widePeriod); // RQ5
    assign lowMatch = (lowCount == lowPeriod); // RQ17
    assign highMatch = (highCount == highPeriod); // RQ17
    assign lowCarry = &lowCount; // RQ20
    assign wideEvent = wideMode && lowTick && wideMatch;
    assign lowEvent = !wideMode && lowTick && lowMatch;
    assign highEvent = !wideMode && highTick && highMatch;

    // bus decode
    assign addrValid = (phaseAddr <= PT_IRQ_FLAG_ADDR) && (phaseAddr[1:0] == 2'b00);
    assign wrLowCtrl = phaseWrite && phaseAddr == PT_LOW_CTRL_ADDR;
    assign wrHighCtrl = phaseWrite && phaseAddr == PT_HIGH_CTRL_ADDR;
    assign wrLowPer = phaseWrite && phaseAddr == PT_LOW_PERIOD_ADDR;
    assign wrHighPer = phaseWrite && phaseAddr == PT_HIGH_PERIOD_ADDR;
    assign wrLowCnt = phaseWrite && phaseAddr == PT_LOW_COUNT_ADDR;
    assign wrHighCnt = phaseWrite && phaseAddr == PT_HIGH_COUNT_ADDR;
    assign wrIrq = phaseWrite && phaseAddr == PT_IRQ_CTRL_ADDR;
    assign wrFlag = phaseWrite && phaseAddr == PT_IRQ_FLAG_ADDR;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        next_hrdata = 32'h0000_0000;
        unique case (haddr)
            PT_LOW_CTRL_ADDR: next_hrdata[15:0] = lowCtrl;
            PT_HIGH_CTRL_ADDR: next_hrdata[15:0] = highCtrl;
            PT_LOW_PERIOD_ADDR: next_hrdata[WIDTH-1:0] = lowPeriod;
            PT_HIGH_PERIOD_ADDR: next_hrdata[WIDTH-1:0] = highPeriod;
            PT_LOW_COUNT_ADDR: next_hrdata[WIDTH-1:0] = lowCount; // RQ14
            PT_HIGH_COUNT_ADDR: next_hrdata[WIDTH-1:0] = highCount; // RQ14
            PT_IRQ_CTRL_ADDR: next_hrdata[15:0] = irqCtrl;
            PT_IRQ_FLAG_ADDR: next_hrdata[1:0] = {highIrqFlag, lowIrqFlag};
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    // address phase capture, read data loaded for the data phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phaseWrite <= 1'b0;
            phaseAddr <= 12'h000;
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            phaseWrite <= hsel && htrans == PT_HTRANS_NONSEQ && hwrite && hsize == PT_HSIZE_WORD;
            phaseAddr <= haddr;
            hrdata <= next_hrdata;
        end
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lowCtrl <= 16'h0000;
            highCtrl <= 16'h0000;
            lowPeriod <= PT_PERIOD_RESET[WIDTH-1:0];
            highPeriod <= PT_PERIOD_RESET[WIDTH-1:0];
            irqCtrl <= 16'h0000;
        end else if (addrValid) begin
            if (wrLowCtrl) lowCtrl <= hwdata[15:0] & PT_CTRL_MASK;
            // wide-mode select lives only in the low control word
            if (wrHighCtrl) highCtrl <= hwdata[15:0] & PT_CTRL_MASK & ~(16'h0001 << PT_WIDE_BIT);
            if (wrLowPer) lowPeriod <= hwdata[WIDTH-1:0];
            if (wrHighPer) highPeriod <= hwdata[WIDTH-1:0];
            if (wrIrq) irqCtrl <= hwdata[15:0];
        end
    end

    // counters
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lowCount <= '0;
            highCount <= '0;
        end else if (wrLowCnt && addrValid) begin
            lowCount <= hwdata[WIDTH-1:0];
        end else if (wrHighCnt && addrValid) begin
            highCount <= hwdata[WIDTH-1:0];
        end else if (wideMode) begin
            if (wideEvent) begin
                lowCount <= '0; // RQ19
                highCount <= '0; // RQ19
            end else if (lowTick) begin
                lowCount <= lowCount + 1'b1; // RQ3
                if (lowCarry) highCount <= highCount + 1'b1; // RQ20
            end
        end else begin
            if (lowEvent) lowCount <= '0; // RQ19
            else if (lowTick) lowCount <= lowCount + 1'b1; // RQ2
            if (highEvent) highCount <= '0; // RQ19
            else if (highTick) highCount <= highCount + 1'b1; // RQ2
        end
    end

    // sticky flags: hardware set wins over write-one-to-clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lowIrqFlag <= 1'b0;
            highIrqFlag <= 1'b0;
            adcTrigger <= 1'b0;
        end else begin
            lowIrqFlag <= lowEvent || (lowIrqFlag && !(wrFlag && addrValid && hwdata[0])); // RQ17 RQ19
            highIrqFlag <= highEvent || wideEvent || (highIrqFlag && !(wrFlag && addrValid && hwdata[1])); // RQ9 RQ5
            adcTrigger <= wideEvent || highEvent; // RQ6
        end
    end

    // wide mode reports through the high enable and priority
    assign lowIrqReq = lowIrqFlag && irqCtrl[PT_LOW_IE_BIT];
    assign highIrqReq = highIrqFlag && irqCtrl[PT_HIGH_IE_BIT]; // RQ15
    assign lowIrqPriority = irqCtrl[PT_LOW_IP_LO +: PT_IP_WIDTH];
    assign highIrqPriority = irqCtrl[PT_HIGH_IP_LO +: PT_IP_WIDTH]; // RQ15
endmodule // pt_paired_timer

// >>> tb/pt_paired_timer_chk.sv
// port assertions for the paired timer
module pt_paired_timer_chk
    import pt_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // events
    input wire logic lowIrqFlag,
    input wire logic highIrqFlag,
    input wire logic lowIrqReq,
    input wire logic highIrqReq,
    input wire logic [2:0] lowIrqPriority,
    input wire logic adcTrigger
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic addrOk = hsel && hready && htrans == PT_HTRANS_NONSEQ;
    logic rdPh;
    logic rdOff;
    logic flagWr;
    logic ctlWr;
    // data-phase markers, one cycle behind the address phase
    always_ff @(posedge sys_clk) begin
        rdPh <= addrOk && !hwrite;
        rdOff <= addrOk && !hwrite && haddr > PT_IRQ_FLAG_ADDR;
        flagWr <= addrOk && hwrite && haddr == PT_IRQ_FLAG_ADDR;
        ctlWr <= addrOk && hwrite && haddr == PT_IRQ_CTRL_ADDR;
    end
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    unmapped_zero_a: assert property (rdOff |-> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rdPh |-> hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    low_sticky_a: assert property (lowIrqFlag && !flagWr |=> lowIrqFlag)
        else $error("low flag dropped");
    high_sticky_a: assert property (highIrqFlag && !flagWr |=> highIrqFlag)
        else $error("high flag dropped");
    low_req_a: assert property (lowIrqReq |-> lowIrqFlag)
        else $error("low request without flag");
    high_req_a: assert property (highIrqReq |-> highIrqFlag)
        else $error("high request without flag");
    adc_source_a: assert property (adcTrigger |-> highIrqFlag || $past(highIrqFlag))
        else $error("trigger without high match");
    prio_write_a: assert property (!$stable(lowIrqPriority) |-> $past(ctlWr))
        else $error("priority moved without write");
    cover property (adcTrigger);
    cover property (highIrqReq);
    cover property (lowIrqReq);
endmodule // pt_paired_timer_chk

bind pt_paired_timer pt_paired_timer_chk chk (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lowIrqFlag(lowIrqFlag), .highIrqFlag(highIrqFlag), .lowIrqReq(lowIrqReq),
    .highIrqReq(highIrqReq), .lowIrqPriority(lowIrqPriority), .adcTrigger(adcTrigger));

// >>> tb/pt_paired_timer_test.sv
// register-level bench for the paired timer
module pt_paired_timer_test
    import pt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0;
    logic rst = 1;
    logic hsel = 0;
    logic hwrite = 0;
    logic lowGate = 0;
    logic lowExtClock = 0;
    logic cpuIdle = 0;
    logic [1:0] htrans = 2'h0;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic hreadyout;
    logic lowIrqFlag, highIrqFlag, lowIrqReq, highIrqReq, adcTrigger;
    logic [2:0] lowIrqPriority, highIrqPriority;
    int fail_count = 0;
    int comparisons = 0;
    int adcCount = 0;
    int n;
    int ratio[4] = '{1, 8, 64, 256};
    pt_paired_timer DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(PT_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .lowExtClock(lowExtClock), .highExtClock(1'h0), .lowGate(lowGate),
        .highGate(1'h0), .cpuIdle(cpuIdle), .lowIrqFlag(lowIrqFlag), .highIrqFlag(highIrqFlag),
        .lowIrqReq(lowIrqReq), .highIrqReq(highIrqReq), .lowIrqPriority(lowIrqPriority),
        .highIrqPriority(highIrqPriority), .adcTrigger(adcTrigger));
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (adcTrigger === 1'h1) adcCount++;
    task automatic check(input string s, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // one single transfer; waits on ready rather than assuming zero waits
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1;
        haddr <= a;
        htrans <= PT_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
        rv = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string s);
        bus(0, a, 32'h0000_0000);
        check(s, rv, e);
    endtask
    task automatic gap();
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (adcTrigger !== 1'h1 && n < 4000);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #2_000_000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        rd(PT_LOW_PERIOD_ADDR, 32'h0000_FFFF, "period reset");
        rd(PT_LOW_CTRL_ADDR, 32'h0000_0000, "ctrl reset");
        bus(1, PT_LOW_CTRL_ADDR, 32'hFFFF_FFFF);
        rd(PT_LOW_CTRL_ADDR, {16'h0000, PT_CTRL_MASK}, "ctrl bits");
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_0000);
        bus(1, 12'h020, 32'h0000_1234);
        rd(12'h020, 32'h0000_0000, "unmapped");
        $display("done reset");
        adcCount = 0;
        bus(1, PT_LOW_PERIOD_ADDR, 32'h0000_0003);
        bus(1, PT_IRQ_CTRL_ADDR, 32'h0000_0051);
        bus(1, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_8000);
        for (int i = 0; i < 50 && lowIrqFlag !== 1'h1; i++) @(posedge sys_clk);
        check("low req", lowIrqReq, 1'h1);
        check("low prio", lowIrqPriority, 3'h5);
        check("low trigger", adcCount, 0);
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_0000);
        rd(PT_IRQ_FLAG_ADDR, 32'h0000_0001, "low flag");
        bus(0, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        check("low wrap", rv <= 3, 1'h1);
        $display("done split low");
        bus(1, PT_HIGH_PERIOD_ADDR, 32'h0000_0001);
        foreach (ratio[i]) begin
            bus(1, PT_HIGH_CTRL_ADDR, 32'h0000_8000 | (i << PT_PS_LO));
            gap();
            gap();
            check("trigger gap", n, 2 * ratio[i]);
        end
        bus(1, PT_HIGH_CTRL_ADDR, 32'h0000_0000);
        $display("done split high");
        bus(1, PT_LOW_COUNT_ADDR, 32'h0000_FFFE);
        bus(1, PT_HIGH_COUNT_ADDR, 32'h0000_0000);
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_8008);
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_0008);
        rd(PT_HIGH_COUNT_ADDR, 32'h0000_0001, "carry");
        // running high control must be ignored while paired
        bus(1, PT_HIGH_CTRL_ADDR, 32'h0000_8030);
        bus(1, PT_LOW_PERIOD_ADDR, 32'h0000_0005);
        bus(1, PT_HIGH_PERIOD_ADDR, 32'h0000_0001);
        bus(1, PT_IRQ_FLAG_ADDR, 32'h0000_0003);
        bus(1, PT_IRQ_CTRL_ADDR, 32'h0000_0602);
        adcCount = 0;
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_8008);
        for (int i = 0; i < 40 && highIrqFlag !== 1'h1; i++) @(posedge sys_clk);
        check("wide req", highIrqReq, 1'h1);
        check("wide prio", highIrqPriority, 3'h6);
        rd(PT_IRQ_FLAG_ADDR, 32'h0000_0002, "wide flag");
        check("wide trigger", adcCount, 1);
        rd(PT_HIGH_COUNT_ADDR, 32'h0000_0000, "wide restart");
        $display("done wide");
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_0000);
        bus(1, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        bus(1, PT_LOW_PERIOD_ADDR, 32'h0000_FFFF);
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_8040);
        rd(PT_LOW_COUNT_ADDR, 32'h0000_0000, "gate closed");
        lowGate <= 1;
        bus(0, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        bus(0, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        check("gate open", rv != 0, 1'h1);
        $display("done gate");
        // idle-stop set: the half must freeze while the core idles
        cpuIdle <= 1;
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_A000);
        bus(1, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        rd(PT_LOW_COUNT_ADDR, 32'h0000_0000, "idle stop");
        cpuIdle <= 0;
        bus(0, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        bus(0, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        check("idle resume", rv != 0, 1'h1);
        $display("done idle");
        bus(1, PT_LOW_CTRL_ADDR, 32'h0000_8002);
        bus(1, PT_LOW_COUNT_ADDR, 32'h0000_0000);
        // pin already mapped by software; five slow rising edges on it
        repeat (5) begin
            lowExtClock <= 1;
            repeat (4) @(posedge sys_clk);
            lowExtClock <= 0;
            repeat (4) @(posedge sys_clk);
        end
        rd(PT_LOW_COUNT_ADDR, 32'h0000_0005, "ext edges");
        $display("done external clock");
        conclude();
    end
endmodule // pt_paired_timer_test
